// >>> verilog/uar_receiver.sv
// Purpose: asynchronous serial receiver with avalon-mm registers
// Assumes: rx_pin synchronous to clock; clock 40 MHz
// Notes:   one-character receive buffer behind the shift register
module uar_receiver import uar_pkg::*; (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        receive_data_pin,
  output logic             irq,
  output logic             receive_irq
);
  // ==========================================================
  // reset release
  logic [1:0] rst_q;
  logic       rst_n;
  // two-flop release of the asynchronous reset
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) rst_q <= 2'b00;
    else       rst_q <= {rst_q[0], 1'b1};
  end
  assign rst_n = rst_q[1];

  // ==========================================================
  // state
  logic [7:0]    sta;         // software control bits only
  logic [7:0]    baud_divisor_low;
  logic [7:0]    baud_divisor_high;
  logic [7:0]    bcon;
  logic [7:0]    icon;
  logic [3:0]    irq_st;
  logic [3:0]    irq_en;
  uar_char_t     rbuf;
  logic          rcv;         // receive flag
  logic          overrun_error_flag;
  logic          rx_prev;
  uar_wk_state_t wk;
  logic [7:0]    next_sta;
  logic [7:0]    next_brgl;
  logic [7:0]    next_high_speed_baud_select;
  logic [7:0]    next_bcon;
  logic [7:0]    next_icon;
  logic [3:0]    next_irq_st;
  logic [3:0]    next_irq_en;
  uar_char_t     next_rbuf;
  logic          next_rcv;
  logic          next_overrun_error_flag;
  uar_wk_state_t next_wk;
  logic          next_wait;
  logic [31:0]   next_rdata;
  logic          next_irq;
  logic          next_rirq;
  logic       tick;
  logic       rx_done;
  uar_char_t  rx_ch;
  logic       run;
  logic       char_ok;
  logic       load;
  logic       ovr_set;
  logic       wake_done;
  logic       wr;
  logic       pop;
  logic [6:0] tpb;
  logic [3:0] ev;

  // ==========================================================
  // helpers
  function automatic logic [6:0] ticks_per_bit(input logic wide,
                                               input logic hspd);
    if (wide && hspd)      ticks_per_bit = UAR_TPB_FAST;
    else if (wide || hspd) ticks_per_bit = UAR_TPB_MID;
    else                   ticks_per_bit = UAR_TPB_SLOW;
  endfunction : ticks_per_bit
  function automatic logic wr_hit(input logic       w,
                                  input logic [5:0] a,
                                  input logic [5:0] off);
    wr_hit = w && (a == off);
  endfunction : wr_hit

  // ==========================================================
  // submodules
  uar_baud_gen u_baud (
    .clock   (clock),
    .rst_n   (rst_n),
    .enable  (run),
    .wide    (bcon[UAR_BCON_WIDE]),
    .divisor ({baud_divisor_high, baud_divisor_low}),
    .tick    (tick)
  );
  uar_rx_shift u_shift (
    .clock (clock),
    .rst_n (rst_n),
    .run   (run),
    .tick  (tick),
    .rx    (receive_data_pin),
    .nine  (sta[UAR_STA_RX9]),
    .tpb   (tpb),
    .done  (rx_done),
    .ch    (rx_ch)
  );

  // ==========================================================
  // receive path decisions
  always_comb begin
    tpb = ticks_per_bit(bcon[UAR_BCON_WIDE], bcon[UAR_BCON_HSPD]);
    run = sta[UAR_STA_SERIAL_PORT_ENABLE] && !sta[UAR_STA_SYNC]
          && sta[UAR_STA_CONTINUOUS_RECEIVE_ENABLE] && (wk == UAR_WK_OFF)
          && !bcon[UAR_BCON_WUE];
    char_ok = rx_done && (!(sta[UAR_STA_RX9] && sta[UAR_STA_ADDRESS_DETECT_ENABLE])
                          || rx_ch.bit9);
    wr  = avs_write && !avs_waitrequest && avs_byteenable[0];
    pop = avs_read && !avs_waitrequest && (avs_address == UAR_ADDR_DATA);
    // overrun holds the buffer; no load until it is cleared
    load    = char_ok && !overrun_error_flag && (!rcv || pop);
    ovr_set = char_ok && !overrun_error_flag && rcv && !pop;
  end

  // ==========================================================
  // wake-up on break watcher
  always_comb begin
    next_wk   = wk;
    wake_done = 1'b0;
    case (wk)
      UAR_WK_OFF:
        if (bcon[UAR_BCON_WUE] && sta[UAR_STA_SERIAL_PORT_ENABLE])
          next_wk = UAR_WK_FALL;
      UAR_WK_FALL:
        if (rx_prev && !receive_data_pin) next_wk = UAR_WK_RISE;
      UAR_WK_RISE:
        if (!rx_prev && receive_data_pin) begin
          wake_done = 1'b1;
          next_wk   = UAR_WK_OFF;
        end
      default: next_wk = UAR_WK_OFF;
    endcase
    if (!bcon[UAR_BCON_WUE] || !sta[UAR_STA_SERIAL_PORT_ENABLE]) begin
      next_wk   = UAR_WK_OFF;
      wake_done = 1'b0;
    end
  end

  // ==========================================================
  // buffer, flags and control registers
  always_comb begin
    next_sta  = sta;
    next_brgl = baud_divisor_low;
    next_high_speed_baud_select = baud_divisor_high;
    next_bcon = bcon;
    next_icon = icon;
    next_irq_en = irq_en;
    next_rbuf = rbuf;
    if (wr_hit(wr, avs_address, UAR_ADDR_STA)) begin
      next_sta = avs_writedata[7:0];
      next_sta[UAR_STA_FRAMING_ERROR_FLAG] = 1'b0;
      next_sta[UAR_STA_OVERRUN_ERROR_FLAG] = 1'b0;
      next_sta[UAR_STA_BIT9] = 1'b0;
    end
    if (wr_hit(wr, avs_address, UAR_ADDR_BRGL))
      next_brgl = avs_writedata[7:0];
    if (wr_hit(wr, avs_address, UAR_ADDR_HIGH_SPEED_BAUD_SELECT))
      next_high_speed_baud_select = avs_writedata[7:0];
    if (wake_done) next_bcon[UAR_BCON_WUE] = 1'b0;
    if (wr_hit(wr, avs_address, UAR_ADDR_BCON))
      next_bcon = {4'h0, avs_writedata[3:0]};
    if (wr_hit(wr, avs_address, UAR_ADDR_ICON))
      next_icon = {5'h00, avs_writedata[2:0]};
    if (wr_hit(wr, avs_address, UAR_ADDR_IEN))
      next_irq_en = avs_writedata[3:0];
    if (load) begin
      next_rbuf = rx_ch;
      // ninth bit reads one in address mode
      next_rbuf.bit9 = rx_ch.bit9 | sta[UAR_STA_ADDRESS_DETECT_ENABLE];
    end else if (wake_done) begin
      next_rbuf = '0;
    end
    // set wins over the clear by reading
    next_rcv = load || wake_done || (rcv && !pop);
    // overrun cleared only by dropping enable
    next_overrun_error_flag = sta[UAR_STA_CONTINUOUS_RECEIVE_ENABLE] && (overrun_error_flag || ovr_set);
    // sticky events, set wins over write-one clear
    ev = '0;
    ev[UAR_EV_CHAR] = load || wake_done;
    ev[UAR_EV_FRAMING_ERROR_FLAG] = load && rx_ch.framing_error_flag;
    ev[UAR_EV_OVERRUN_ERROR_FLAG] = ovr_set;
    ev[UAR_EV_WAKE] = wake_done;
    next_irq_st = irq_st;
    if (wr_hit(wr, avs_address, UAR_ADDR_ICLR))
      next_irq_st = irq_st & ~avs_writedata[3:0];
    next_irq_st = next_irq_st | ev;
    next_irq = |(irq_st & irq_en);
    next_rirq = rcv && icon[UAR_ICON_RECEIVE_IRQ_ENABLE] && icon[UAR_ICON_PERIPHERAL_INTERRUPT_ENABLE]
                && icon[UAR_ICON_GIE];
  end

  // ==========================================================
  // avalon slave: one wait state, read data registered
  always_comb begin
    next_wait  = !((avs_read || avs_write) && avs_waitrequest);
    next_rdata = avs_readdata;
    if (avs_read && avs_waitrequest) begin
      next_rdata = UAR_RD_UNMAP;
      case (avs_address)
        UAR_ADDR_STA: begin
          next_rdata[7:0] = sta;
          next_rdata[UAR_STA_FRAMING_ERROR_FLAG] = rbuf.framing_error_flag;
          next_rdata[UAR_STA_OVERRUN_ERROR_FLAG] = overrun_error_flag;
          next_rdata[UAR_STA_BIT9] = rbuf.bit9;
        end
        // low byte of the buffered character
        UAR_ADDR_DATA: next_rdata[7:0] = rbuf.data;
        UAR_ADDR_BRGL: next_rdata[7:0] = baud_divisor_low;
        UAR_ADDR_HIGH_SPEED_BAUD_SELECT: next_rdata[7:0] = baud_divisor_high;
        UAR_ADDR_BCON: next_rdata[7:0] = bcon;
        UAR_ADDR_IST:  next_rdata[3:0] = irq_st;
        UAR_ADDR_IEN:  next_rdata[3:0] = irq_en;
        UAR_ADDR_ICON: next_rdata[7:0] = icon;
        default:       next_rdata = UAR_RD_UNMAP;
      endcase
    end
  end
  // all registers of the block except the reset release pair
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sta               <= UAR_RST_BYTE;
      baud_divisor_low  <= UAR_RST_BYTE;
      baud_divisor_high <= UAR_RST_BYTE;
      bcon              <= UAR_RST_BYTE;
      icon              <= UAR_RST_BYTE;
      irq_st            <= 4'h0;
      irq_en            <= 4'h0;
      rbuf              <= '0;
      rcv               <= 1'b0;
      overrun_error_flag              <= 1'b0;
      rx_prev           <= 1'b1;
      wk                <= UAR_WK_OFF;
      avs_waitrequest   <= 1'b1;
      avs_readdata      <= UAR_RD_UNMAP;
      irq               <= 1'b0;
      receive_irq       <= 1'b0;
    end else begin
      sta               <= next_sta;
      baud_divisor_low  <= next_brgl;
      baud_divisor_high <= next_high_speed_baud_select;
      bcon              <= next_bcon;
      icon              <= next_icon;
      irq_st            <= next_irq_st;
      irq_en            <= next_irq_en;
      rbuf              <= next_rbuf;
      rcv               <= next_rcv;
      overrun_error_flag              <= next_overrun_error_flag;
      rx_prev           <= receive_data_pin;
      wk                <= next_wk;
      avs_waitrequest   <= next_wait;
      avs_readdata      <= next_rdata;
      irq               <= next_irq;
      receive_irq       <= next_rirq;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_flag_on_load: assert property (
    load |=> rcv ##1 (rcv || $past(pop)))
    else $error("receive flag not set after load");
  a_eight_bit_mode: assert property (
    load && !sta[UAR_STA_RX9] && !sta[UAR_STA_ADDRESS_DETECT_ENABLE] |=> !rbuf.bit9)
    else $error("ninth bit seen in eight-bit mode");
  a_sync_blocks: assert property (
    $past(sta[UAR_STA_SYNC]) && sta[UAR_STA_SYNC] |-> !rx_done)
    else $error("reception in clocked mode");
  a_continuous_receive_enable_gates: assert property (
    $past(!sta[UAR_STA_CONTINUOUS_RECEIVE_ENABLE]) && !sta[UAR_STA_CONTINUOUS_RECEIVE_ENABLE] |-> !load)
    else $error("reception while receive disabled");
  a_addr_filter: assert property (
    rx_done && sta[UAR_STA_RX9] && sta[UAR_STA_ADDRESS_DETECT_ENABLE] && !rx_ch.bit9
    |=> rcv == $past(rcv && !pop))
    else $error("address filter let a data character in");
  a_addr_bit9: assert property (
    load && sta[UAR_STA_ADDRESS_DETECT_ENABLE] |=> rbuf.bit9)
    else $error("ninth bit not one in address mode");
  a_overrun_error_flag_clear: assert property (
    !sta[UAR_STA_CONTINUOUS_RECEIVE_ENABLE] |=> !overrun_error_flag)
    else $error("overrun survived receive disable");
  a_overrun_error_flag_hold: assert property (
    overrun_error_flag && sta[UAR_STA_CONTINUOUS_RECEIVE_ENABLE] |=> overrun_error_flag)
    else $error("overrun dropped while enabled");
  a_data_read: assert property (
    avs_read && avs_waitrequest && avs_address == UAR_ADDR_DATA
    |=> !avs_waitrequest && avs_readdata[7:0] == $past(rbuf.data))
    else $error("data read returned wrong byte");
  a_rirq_gate: assert property (
    receive_irq |-> $past(rcv) && $past(icon[UAR_ICON_GIE])
    && $past(icon[UAR_ICON_PERIPHERAL_INTERRUPT_ENABLE]) && $past(icon[UAR_ICON_RECEIVE_IRQ_ENABLE]))
    else $error("receive interrupt without all enables");
  a_framing_error_flag_carried: assert property (
    load |=> rbuf.framing_error_flag == $past(rx_ch.framing_error_flag))
    else $error("framing error not delivered with character");
  a_break_report: assert property (
    load && rx_ch.framing_error_flag && rx_ch.data == 8'h00
    |=> rcv && rbuf.framing_error_flag && rbuf.data == 8'h00)
    else $error("break not reported");
  a_wake_flag: assert property (
    wake_done |=> rcv && rbuf.data == 8'h00 ##1 run || !sta[UAR_STA_CONTINUOUS_RECEIVE_ENABLE]
    || bcon[UAR_BCON_WUE] || sta[UAR_STA_SYNC])
    else $error("wake-up did not flag and resume");
endmodule : uar_receiver

// >>> verilog/uar_pkg.sv
// Purpose: shared constants and types of the serial receive block
// Assumes: 32-bit avalon-mm slave, byte addresses, one word per register
// Notes:   registers are at most eight bits wide, in the low byte lane
package uar_pkg;
  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [5:0] UAR_ADDR_STA  = 6'h00; // status/control
  localparam logic [5:0] UAR_ADDR_DATA = 6'h04; // receive data
  localparam logic [5:0] UAR_ADDR_BRGL = 6'h08; // divisor low
  localparam logic [5:0] UAR_ADDR_HIGH_SPEED_BAUD_SELECT = 6'h0C; // divisor high
  localparam logic [5:0] UAR_ADDR_BCON = 6'h10; // baud control
  localparam logic [5:0] UAR_ADDR_IST  = 6'h14; // sticky status
  localparam logic [5:0] UAR_ADDR_ICLR = 6'h18; // write-one clear
  localparam logic [5:0] UAR_ADDR_IEN  = 6'h1C; // event enable
  localparam logic [5:0] UAR_ADDR_ICON = 6'h20; // interrupt control
  // ==========================================================
  // field positions
  localparam int UAR_STA_SERIAL_PORT_ENABLE  = 7;
  localparam int UAR_STA_RX9   = 6;
  localparam int UAR_STA_SYNC  = 5;
  localparam int UAR_STA_CONTINUOUS_RECEIVE_ENABLE  = 4;
  localparam int UAR_STA_ADDRESS_DETECT_ENABLE = 3;
  localparam int UAR_STA_FRAMING_ERROR_FLAG  = 2;
  localparam int UAR_STA_OVERRUN_ERROR_FLAG  = 1;
  localparam int UAR_STA_BIT9  = 0;
  localparam int UAR_BCON_WIDE = 3;
  localparam int UAR_BCON_HSPD = 2;
  localparam int UAR_BCON_WUE  = 1;
  localparam int UAR_BCON_ABD  = 0;
  localparam int UAR_ICON_RECEIVE_IRQ_ENABLE = 0;
  localparam int UAR_ICON_PERIPHERAL_INTERRUPT_ENABLE = 1;
  localparam int UAR_ICON_GIE  = 2;
  localparam int UAR_EV_CHAR   = 0;
  localparam int UAR_EV_FRAMING_ERROR_FLAG   = 1;
  localparam int UAR_EV_OVERRUN_ERROR_FLAG   = 2;
  localparam int UAR_EV_WAKE   = 3;
  // ==========================================================
  // reset values and timing counts
  localparam logic [7:0]  UAR_RST_BYTE   = 8'h00;
  localparam logic [31:0] UAR_RD_UNMAP   = 32'h0000_0000;
  localparam logic [6:0]  UAR_TPB_SLOW   = 7'h40; // 64 ticks per bit
  localparam logic [6:0]  UAR_TPB_MID    = 7'h10; // 16 ticks per bit
  localparam logic [6:0]  UAR_TPB_FAST   = 7'h04; // 4 ticks per bit
  // ==========================================================
  // types
  typedef struct packed {
    logic       framing_error_flag;
    logic       bit9;
    logic [7:0] data;
  } uar_char_t;
  typedef enum logic [4:0] {
    UAR_RX_IDLE  = 5'b00001,
    UAR_RX_START = 5'b00010,
    UAR_RX_DATA  = 5'b00100,
    UAR_RX_STOP  = 5'b01000,
    UAR_RX_BRK   = 5'b10000
  } uar_rx_state_t;
  typedef enum logic [2:0] {
    UAR_WK_OFF  = 3'b001,
    UAR_WK_FALL = 3'b010,
    UAR_WK_RISE = 3'b100
  } uar_wk_state_t;
endpackage : uar_pkg

// >>> verilog/uar_baud_gen.sv
// Purpose: sample tick generator from the sixteen-bit divisor
// Assumes: divisor is stable while the receiver runs
// Notes:   one tick every divisor+1 clocks in wide mode, low divisor byte+1 in narrow mode
module uar_baud_gen import uar_pkg::*; (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        enable,
  input  wire logic        wide,
  input  wire logic [15:0] divisor,
  output logic             tick
);
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic        next_tick;
  logic [15:0] reload;

  // ==========================================================
  // narrow mode uses only the low divisor byte
  always_comb begin
    reload    = wide ? divisor : {8'h00, divisor[7:0]};
    next_tick = 1'b0;
    next_cnt  = cnt;
    if (!enable) begin
      next_cnt = reload;
    end else if (cnt == 16'h0000) begin
      next_tick = 1'b1;
      next_cnt  = reload;
    end else begin
      next_cnt = cnt - 16'h0001;
    end
  end

  // counter and tick registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt  <= 16'h0000;
      tick <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      tick <= next_tick;
    end
  end
endmodule : uar_baud_gen

// >>> verilog/uar_rx_shift.sv
// Purpose: receive shift register, start/data/stop framing
// Assumes: rx is synchronous to clock, idle high
// Notes:   samples once per bit at the bit centre
module uar_rx_shift import uar_pkg::*; (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic       tick,
  input  wire logic       rx,
  input  wire logic       nine,
  input  wire logic [6:0] tpb,
  output logic            done,
  output uar_char_t       ch
);
  uar_rx_state_t state;
  uar_rx_state_t next_state;
  logic [6:0]    cnt;
  logic [6:0]    next_cnt;
  logic [3:0]    nbit;
  logic [3:0]    next_nbit;
  logic [8:0]    sh;
  logic [8:0]    next_sh;
  logic          next_done;
  uar_char_t     next_ch;

  // ==========================================================
  // framing state machine
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_nbit  = nbit;
    next_sh    = sh;
    next_done  = 1'b0;
    next_ch    = ch;
    case (state)
      UAR_RX_IDLE: begin
        next_cnt  = 7'h00;
        next_nbit = 4'h0;
        if (!rx) next_state = UAR_RX_START;
      end
      UAR_RX_START: if (tick) begin
        // half a bit to the start bit centre
        next_cnt = cnt + 7'h01;
        if (cnt == ((tpb >> 1) - 7'h01)) begin
          next_cnt   = 7'h00;
          next_state = rx ? UAR_RX_IDLE : UAR_RX_DATA;
        end
      end
      UAR_RX_DATA: if (tick) begin
        next_cnt = cnt + 7'h01;
        if (cnt == tpb - 7'h01) begin
          next_cnt  = 7'h00;
          next_sh   = {rx, sh[8:1]};
          next_nbit = nbit + 4'h1;
          if (next_nbit == (nine ? 4'h9 : 4'h8))
            next_state = UAR_RX_STOP;
        end
      end
      UAR_RX_STOP: if (tick) begin
        next_cnt = cnt + 7'h01;
        if (cnt == tpb - 7'h01) begin
          next_done    = 1'b1;
          next_ch.data = nine ? sh[7:0] : sh[8:1];
          next_ch.bit9 = nine & sh[8];
          next_ch.framing_error_flag = !rx;
          // a break holds the line low; wait for it to rise
          next_state   = rx ? UAR_RX_IDLE : UAR_RX_BRK;
        end
      end
      UAR_RX_BRK: if (rx) next_state = UAR_RX_IDLE;
      default: next_state = UAR_RX_IDLE;
    endcase
    if (!run) begin
      next_state = UAR_RX_IDLE;
      next_done  = 1'b0;
    end
  end

  // framing registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= UAR_RX_IDLE;
      cnt   <= 7'h00;
      nbit  <= 4'h0;
      sh    <= 9'h000;
      done  <= 1'b0;
      ch    <= '0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
      nbit  <= next_nbit;
      sh    <= next_sh;
      done  <= next_done;
      ch    <= next_ch;
    end
  end
endmodule : uar_rx_shift

// >>> tb/uar_tx_model.sv
// Purpose: remote serial transmitter on the receive line
// Assumes: line idles high; bits change right after a clock edge
// Notes:   bit time is handed over in clocks with every call
module uar_tx_model (
  input  wire logic clock,
  output logic      line
);
  timeunit 1ns;
  timeprecision 1ps;
  initial line = 1'b1;
  // ==========================================================
  // frame sender: start bit, data lsb first, stop bit, then idle
  // a low stop bit makes a break-like frame
  task automatic send(input logic [8:0] d, input int nb,
                      input logic stp, input int bt);
    for (int i = -1; i <= nb; i++) begin
      line <= (i < 0) ? 1'b0 : (i == nb) ? stp : d[i];
      repeat (bt) @(posedge clock);
    end
    line <= 1'b1;
    @(posedge clock);
  endtask : send
  // ==========================================================
  // bare low pulse: one falling and one rising edge
  task automatic pulse(input int n);
    line <= 1'b0;
    repeat (n) @(posedge clock);
    line <= 1'b1;
    @(posedge clock);
  endtask : pulse
endmodule : uar_tx_model

// >>> tb/test_uar_receiver.sv
// Purpose: self-checking bench of the serial receive block
// Assumes: 16 clocks per bit (divisor 3, wide and fast bits set)
// Notes:   the remote transmitter is a behavioural model
module test_uar_receiver import uar_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BT = 16;
  logic        clock, rstn, rd, wr, wq, line, irq, rirq;
  logic [5:0]  adr;
  logic [31:0] wd, rdata, q;
  int          n_fail, n_compared, cyc;
  uar_receiver i_uar_receiver (.clock(clock), .rstn(rstn),
    .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_byteenable(4'h1), .avs_readdata(rdata),
    .avs_waitrequest(wq), .receive_data_pin(line), .irq(irq),
    .receive_irq(rirq));
  // pin taken as a plain digital input
  uar_tx_model i_uar_tx_model (.clock(clock), .line(line));
  // ==========================================================
  // clock and a hang guard sized well above the expected run
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      end_sim();
    end
  end
  // ==========================================================
  // compare, bus cycle, verdict
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      n_fail++;
      $display("ERROR %0t: got %h want %h", $time, s, e);
    end
  endtask : check
  // request held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [7:0] d);
    adr <= a;
    wd <= {24'h0000_00, d};
    rd <= !w;
    wr <= w;
    do @(posedge clock); while (wq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clock);
  endtask : bus
  task automatic end_sim();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  // ==========================================================
  // scenarios
  task automatic t_basic();
    bus(1, UAR_ADDR_BRGL, 8'h03);
    bus(1, UAR_ADDR_HIGH_SPEED_BAUD_SELECT, 8'h00);
    bus(1, UAR_ADDR_BCON, 8'h0C);
    bus(1, UAR_ADDR_IEN, 8'h01);
    bus(1, UAR_ADDR_ICON, 8'h07);
    // port on, async mode, receiver on
    bus(1, UAR_ADDR_STA, 8'h90);
    i_uar_tx_model.send(9'h0A5, 8, 1'b1, BT);
    check(rirq, 1);
    check(irq, 1);
    bus(0, UAR_ADDR_STA, 8'h00);
    check(q & 32'h0000_0006, 0);
    bus(0, UAR_ADDR_DATA, 8'h00);
    check(q, 32'h0000_00A5);
    repeat (2) @(posedge clock);
    check(rirq, 0);
    bus(0, 6'h3C, 8'h00);
    check(q, 0);
    // global enable off: flag alone raises no receive interrupt
    bus(1, UAR_ADDR_ICON, 8'h03);
    i_uar_tx_model.send(9'h05A, 8, 1'b1, BT);
    check(rirq, 0);
    bus(0, UAR_ADDR_DATA, 8'h00);
    bus(1, UAR_ADDR_ICLR, 8'h0F);
    bus(0, UAR_ADDR_IST, 8'h00);
    check(q, 0);
    check(irq, 0);
    bus(1, UAR_ADDR_ICON, 8'h07);
    $display("test basic done");
  endtask : t_basic
  task automatic t_addr();
    bus(1, UAR_ADDR_STA, 8'hD0);
    i_uar_tx_model.send(9'h13C, 9, 1'b1, BT);
    bus(0, UAR_ADDR_STA, 8'h00);
    check(q & 32'h0000_0001, 1);
    bus(0, UAR_ADDR_DATA, 8'h00);
    check(q, 32'h0000_003C);
    bus(1, UAR_ADDR_ICLR, 8'h0F);
    bus(1, UAR_ADDR_STA, 8'hD8);
    i_uar_tx_model.send(9'h055, 9, 1'b1, BT);
    bus(0, UAR_ADDR_IST, 8'h00);
    check(q, 0);
    i_uar_tx_model.send(9'h1A7, 9, 1'b1, BT);
    bus(0, UAR_ADDR_STA, 8'h00);
    check(q & 32'h0000_0001, 1);
    bus(0, UAR_ADDR_DATA, 8'h00);
    check(q, 32'h0000_00A7);
    bus(1, UAR_ADDR_STA, 8'hD0);
    i_uar_tx_model.send(9'h042, 9, 1'b1, BT);
    check(rirq, 1);
    bus(0, UAR_ADDR_DATA, 8'h00);
    check(q, 32'h0000_0042);
    // address mode without nine-bit: reported ninth bit still one
    bus(1, UAR_ADDR_STA, 8'h98);
    i_uar_tx_model.send(9'h055, 8, 1'b1, BT);
    bus(0, UAR_ADDR_STA, 8'h00);
    check(q & 32'h0000_0001, 1);
    bus(0, UAR_ADDR_DATA, 8'h00);
    check(q, 32'h0000_0055);
    $display("test address done");
  endtask : t_addr
  task automatic t_err();
    bus(1, UAR_ADDR_STA, 8'h90);
    i_uar_tx_model.send(9'h000, 8, 1'b0, BT);
    check(rirq, 1);
    bus(0, UAR_ADDR_STA, 8'h00);
    check(q & 32'h0000_0004, 4);
    bus(0, UAR_ADDR_DATA, 8'h00);
    check(q, 0);
    i_uar_tx_model.send(9'h011, 8, 1'b1, BT);
    i_uar_tx_model.send(9'h022, 8, 1'b1, BT);
    bus(0, UAR_ADDR_STA, 8'h00);
    check(q & 32'h0000_0002, 2);
    bus(0, UAR_ADDR_DATA, 8'h00);
    check(q, 32'h0000_0011);
    bus(1, UAR_ADDR_STA, 8'h80);
    bus(0, UAR_ADDR_STA, 8'h00);
    check(q & 32'h0000_0002, 0);
    bus(1, UAR_ADDR_ICLR, 8'h0F);
    i_uar_tx_model.send(9'h033, 8, 1'b1, BT);
    bus(0, UAR_ADDR_IST, 8'h00);
    check(q, 0);
    // clocked mode select set: asynchronous reception must stay off
    bus(1, UAR_ADDR_STA, 8'hB0);
    i_uar_tx_model.send(9'h044, 8, 1'b1, BT);
    bus(0, UAR_ADDR_IST, 8'h00);
    check(q, 0);
    $display("test errors done");
  endtask : t_err
  task automatic t_wake();
    bus(1, UAR_ADDR_STA, 8'h90);
    bus(1, UAR_ADDR_BCON, 8'h0F);
    i_uar_tx_model.pulse(BT);
    repeat (4) @(posedge clock);
    check(rirq, 1);
    bus(0, UAR_ADDR_IST, 8'h00);
    check(q & 32'h0000_0009, 9);
    bus(0, UAR_ADDR_BCON, 8'h00);
    check(q, 32'h0000_000D);
    bus(0, UAR_ADDR_DATA, 8'h00);
    check(q, 0);
    i_uar_tx_model.send(9'h03C, 8, 1'b1, BT);
    check(rirq, 1);
    bus(0, UAR_ADDR_DATA, 8'h00);
    check(q, 32'h0000_003C);
    $display("test wake done");
  endtask : t_wake
  // ==========================================================
  // main sequence: reset held two cycles, then the scenarios
  initial begin
    rstn = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    adr = 6'h00;
    wd = 32'h0000_0000;
    n_fail = 0;
    n_compared = 0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    repeat (3) @(posedge clock);
    t_basic();
    t_addr();
    t_err();
    t_wake();
    end_sim();
  end
endmodule : test_uar_receiver
